// File: core/eal_autoload_top.sv
// Purpose: configuration autoload from serial memory, Wishbone register file
// Assumes: classic Wishbone, 8-bit byte address, 32-bit data
// Notes:   all outputs registered; pins and memory data double synchronised
//
// The placing of the registers and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
// Contract
// RULE1: after reset release, load automatically, only if memory was detected present
// RULE2: shift memory bits into holding store, then copy to destination registers
// RULE3: during load, I/O-window accesses retry; configuration window still answers
// RULE4: checksum failure returns loadable config registers to defaults; shadow kept
// RULE5: image valid only when 8-bit sum of all 36 bytes equals FFh
// RULE6: memory absent: abort, clear reload-request and contents-valid, keep defaults
// RULE7: sample shared clock/LED pin every clock edge while reset is held
// RULE8: sampled zero means pulled low: skip memory read entirely
// RULE9: false presence is caught by the checksum failure at load end
// RULE10: software drives serial pins directly from control register bits
// RULE11: software setting reload-request rereads memory and reloads registers
// RULE12: while reload-request set, I/O accesses retry, config accesses accepted
// RULE13: station address writes ignored unless misc config bit 8 set
// RULE14: load fills station shadow, misc, burst/bus and two unused registers
// RULE15: station address reads return shadow registers, never the memory
// RULE16: load fetches exactly 18 words from lowest memory address upward
// RULE17: each word read: select, start bit, read opcode, address, 16 data bits
// RULE18: load end clears reload-request, sets contents-valid only on checksum pass
module eal_autoload_top (
  input  wire logic        clk_sys_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  output logic             wb_rty_out,
  input  wire logic        sclk_led_pin_in,
  output logic             sclk_led_pin_out,
  output logic             sclk_led_pin_oe_out,
  output logic             ee_cs_out,
  output logic             ee_di_out,
  input  wire logic        ee_do_in,
  output logic             irq_out
);
  logic        rst_s1, rst_n;
  logic        sk_s1, sk_s2, do_s1, do_s2;
  logic        present;
  eal_pkg::eal_lstate_t state;
  logic [3:0]  dly;
  logic [4:0]  widx;
  logic [7:0]  sum;
  logic        pass;
  logic [7:0]  shadow [16];
  logic [15:0] temp [eal_pkg::WORDS];
  logic [15:0] misc, una, unb, burst;
  logic        reload_request_bit, contents_valid_bit, een, ecs, esk, edi;
  logic [2:0]  irq_st, irq_msk, ev;
  logic        rd_start, rd_busy, rd_done, rd_sk, rd_cs, rd_di;
  logic [15:0] rd_word;
  logic        req, io, retry, wr, loading, go, abort, fin;
  logic [31:0] rdata;

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction

  // reset release through two flops; assertion stays asynchronous
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      rst_s1 <= 1'b0;
      rst_n  <= 1'b0;
    end
    else if (ce_in)
    begin
      rst_s1 <= 1'b1;
      rst_n  <= rst_s1;
    end

  always_ff @(posedge clk_sys_in)
    if (ce_in)
    begin
      sk_s1 <= sclk_led_pin_in;
      sk_s2 <= sk_s1;
      do_s1 <= ee_do_in;
      do_s2 <= do_s1;
    end

  // no async reset here: the strap is what reset time must capture
  always_ff @(posedge clk_sys_in)
    if (ce_in && !rst_n)
      present <= sk_s2; // RULE7 RULE8

  assign req     = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_rty_out;
  assign io      = (wb_adr_in < eal_pkg::IO_LIMIT);
  assign loading = (state != eal_pkg::L_IDLE);
  assign retry   = io && (reload_request_bit || loading); // RULE3 RULE12
  assign wr      = req && wb_we_in && !retry;
  assign go      = (state == eal_pkg::L_DELAY) && (dly == eal_pkg::DLY_LAST) && present;
  assign abort   = (state == eal_pkg::L_DELAY) && (dly == eal_pkg::DLY_LAST) && !present;
  assign fin     = (state == eal_pkg::L_END);
  assign rd_start = (state == eal_pkg::L_START);

  eal_word_reader u_rd (
    .clk_in   (clk_sys_in),
    .rst_n_in (rst_n),
    .ce_in    (ce_in),
    .start_in (rd_start),
    .addr_in  ({1'b0, widx}),
    .do_in    (do_s2),
    .busy_out (rd_busy),
    .done_out (rd_done),
    .word_out (rd_word),
    .sk_out   (rd_sk),
    .cs_out   (rd_cs),
    .di_out   (rd_di)
  );

  // load sequencer; reset lands in the start delay so a load follows release
  always_ff @(posedge clk_sys_in or negedge rst_n)
    if (!rst_n)
    begin
      state <= eal_pkg::L_DELAY; // RULE1
      dly   <= 4'h0;
      widx  <= 5'h00;
      sum   <= 8'h00;
      pass  <= 1'b0;
    end
    else if (ce_in)
    begin
      case (state)
        eal_pkg::L_IDLE:
          if (reload_request_bit)
          begin
            state <= eal_pkg::L_DELAY; // RULE11
            dly   <= 4'h0;
          end
        eal_pkg::L_DELAY:
          if (dly != eal_pkg::DLY_LAST)
            dly <= dly + 4'h1;
          else if (present)
          begin
            state <= eal_pkg::L_START; // RULE16
            widx  <= 5'h00;
            sum   <= 8'h00;
          end
          else
            state <= eal_pkg::L_IDLE; // RULE6 RULE8
        eal_pkg::L_START:
          state <= eal_pkg::L_WAIT;
        eal_pkg::L_WAIT:
          if (rd_done)
          begin
            sum <= sum + rd_word[15:8] + rd_word[7:0]; // RULE5
            if (widx == eal_pkg::WORD_LAST)
              state <= eal_pkg::L_APPLY; // RULE16
            else
            begin
              widx  <= widx + 5'h01;
              state <= eal_pkg::L_START;
            end
          end
        eal_pkg::L_APPLY:
        begin
          pass  <= (sum == eal_pkg::SUM_OK); // RULE5 RULE9
          state <= eal_pkg::L_END;
        end
        eal_pkg::L_END:
          state <= eal_pkg::L_IDLE;
        default:
          state <= eal_pkg::L_IDLE;
      endcase
    end

  // holding store, one word per finished read
  always_ff @(posedge clk_sys_in)
    if (ce_in && state == eal_pkg::L_WAIT && rd_done)
      temp[widx] <= rd_word; // RULE2

  // shadow: filled from the holding store whatever the checksum says
  always_ff @(posedge clk_sys_in or negedge rst_n)
    if (!rst_n)
    begin
      for (int i = 0; i < 16; i++)
        shadow[i] <= 8'h00;
    end
    else if (ce_in)
    begin
      if (state == eal_pkg::L_APPLY)
      begin
        for (int i = 0; i < eal_pkg::W_SHADOW_N; i++)
        begin
          shadow[2*i]   <= temp[i][7:0]; // RULE2 RULE14 RULE4
          shadow[2*i+1] <= temp[i][15:8];
        end
      end
      else if (wr && wb_adr_in <= eal_pkg::A_SHADOW3 && misc[eal_pkg::B_ADDR_WE]) // RULE13
      begin
        for (int b = 0; b < 4; b++)
          if (wb_sel_in[b])
            shadow[{wb_adr_in[3:2], 2'(b)}] <= wb_dat_in[8*b +: 8];
      end
    end

  // loadable config registers: loaded value on pass, defaults on failure
  always_ff @(posedge clk_sys_in or negedge rst_n)
    if (!rst_n)
    begin
      misc  <= eal_pkg::MISC_RST;
      una   <= eal_pkg::UNA_RST;
      unb   <= eal_pkg::UNB_RST;
      burst <= eal_pkg::BURST_RST;
    end
    else if (ce_in)
    begin
      if (fin && pass)
      begin
        misc  <= temp[eal_pkg::W_MISC]; // RULE14
        una   <= temp[eal_pkg::W_UNA];
        unb   <= temp[eal_pkg::W_UNB];
        burst <= temp[eal_pkg::W_BURST];
      end
      else if (fin)
      begin
        misc  <= eal_pkg::MISC_RST; // RULE4 RULE9
        una   <= eal_pkg::UNA_RST;
        unb   <= eal_pkg::UNB_RST;
        burst <= eal_pkg::BURST_RST;
      end
      else if (wr)
      begin
        if (hit(wb_adr_in, eal_pkg::A_MISC))
          misc <= merge16(misc, wb_dat_in, wb_sel_in);
        if (hit(wb_adr_in, eal_pkg::A_UNA))
          una <= merge16(una, wb_dat_in, wb_sel_in);
        if (hit(wb_adr_in, eal_pkg::A_UNB))
          unb <= merge16(unb, wb_dat_in, wb_sel_in);
        if (hit(wb_adr_in, eal_pkg::A_BURST))
          burst <= merge16(burst, wb_dat_in, wb_sel_in);
      end
    end

  // reload-request and contents-valid
  always_ff @(posedge clk_sys_in or negedge rst_n)
    if (!rst_n)
    begin
      reload_request_bit  <= 1'b0;
      contents_valid_bit <= 1'b0;
    end
    else if (ce_in)
    begin
      if (go)
        reload_request_bit <= 1'b1;
      else if (abort)
      begin
        reload_request_bit  <= 1'b0; // RULE6
        contents_valid_bit <= 1'b0;
      end
      else if (fin)
      begin
        reload_request_bit  <= 1'b0; // RULE18
        contents_valid_bit <= pass;
      end
      else if (wr && hit(wb_adr_in, eal_pkg::A_EECTL) && wb_sel_in[1]
               && wb_dat_in[eal_pkg::B_RELOAD_REQUEST_BIT])
        reload_request_bit <= 1'b1; // RULE11
    end

  // direct pin control bits
  always_ff @(posedge clk_sys_in or negedge rst_n)
    if (!rst_n)
    begin
      een <= 1'b0;
      ecs <= 1'b0;
      esk <= 1'b0;
      edi <= 1'b0;
    end
    else if (ce_in && wr && hit(wb_adr_in, eal_pkg::A_EECTL) && wb_sel_in[0])
    begin
      een <= wb_dat_in[eal_pkg::B_EEN]; // RULE10
      ecs <= wb_dat_in[eal_pkg::B_ECS];
      esk <= wb_dat_in[eal_pkg::B_ESK];
      edi <= wb_dat_in[eal_pkg::B_EDI];
    end

  // pin drivers registered; pin stays released during reset for the strap
  always_ff @(posedge clk_sys_in or negedge rst_n)
    if (!rst_n)
    begin
      sclk_led_pin_out    <= 1'b0;
      sclk_led_pin_oe_out <= 1'b0;
      ee_cs_out           <= 1'b0;
      ee_di_out           <= 1'b0;
    end
    else if (ce_in)
    begin
      if (rd_busy || rd_start || rd_done) // no stray clock edge between words
      begin
        sclk_led_pin_out    <= rd_sk; // RULE17
        sclk_led_pin_oe_out <= 1'b1;
        ee_cs_out           <= rd_cs;
        ee_di_out           <= rd_di;
      end
      else if (een && !loading)
      begin
        sclk_led_pin_out    <= esk; // RULE10
        sclk_led_pin_oe_out <= 1'b1;
        ee_cs_out           <= ecs;
        ee_di_out           <= edi;
      end
      else
      begin
        sclk_led_pin_out    <= 1'b0;
        sclk_led_pin_oe_out <= 1'b0;
        ee_cs_out           <= 1'b0;
        ee_di_out           <= 1'b0;
      end
    end

  // interrupt events; set wins over a same-cycle clear
  assign ev = {abort, fin && !pass, fin};

  always_ff @(posedge clk_sys_in or negedge rst_n)
    if (!rst_n)
    begin
      irq_st  <= 3'h0;
      irq_msk <= 3'h0;
      irq_out <= 1'b0;
    end
    else if (ce_in)
    begin
      if (wr && hit(wb_adr_in, eal_pkg::A_IRQST) && wb_sel_in[0])
        irq_st <= (irq_st & ~wb_dat_in[2:0]) | ev;
      else
        irq_st <= irq_st | ev;
      if (wr && hit(wb_adr_in, eal_pkg::A_IRQMSK) && wb_sel_in[0])
        irq_msk <= wb_dat_in[2:0];
      irq_out <= |(irq_st & irq_msk);
    end

  // read mux; shadow reads never touch the memory
  always_comb
  begin
    rdata = 32'h0000_0000;
    if (wb_adr_in <= eal_pkg::A_SHADOW3 && wb_adr_in[1:0] == 2'h0)
      rdata = {shadow[{wb_adr_in[3:2], 2'h3}], shadow[{wb_adr_in[3:2], 2'h2}],
               shadow[{wb_adr_in[3:2], 2'h1}], shadow[{wb_adr_in[3:2], 2'h0}]}; // RULE15
    else if (hit(wb_adr_in, eal_pkg::A_MISC))
      rdata = {16'h0000, misc};
    else if (hit(wb_adr_in, eal_pkg::A_UNA))
      rdata = {16'h0000, una};
    else if (hit(wb_adr_in, eal_pkg::A_UNB))
      rdata = {16'h0000, unb};
    else if (hit(wb_adr_in, eal_pkg::A_BURST))
      rdata = {16'h0000, burst};
    else if (hit(wb_adr_in, eal_pkg::A_EECTL))
    begin
      rdata[eal_pkg::B_RELOAD_REQUEST_BIT]  = reload_request_bit;
      rdata[eal_pkg::B_CONTENTS_VALID_BIT] = contents_valid_bit;
      rdata[eal_pkg::B_EEN]    = een;
      rdata[eal_pkg::B_ECS]    = ecs;
      rdata[eal_pkg::B_ESK]    = esk;
      rdata[eal_pkg::B_EDI]    = edi;
      rdata[eal_pkg::B_EDO]    = do_s2;
    end
    else if (hit(wb_adr_in, eal_pkg::A_IRQST))
      rdata = {29'h0000_0000, irq_st};
    else if (hit(wb_adr_in, eal_pkg::A_IRQMSK))
      rdata = {29'h0000_0000, irq_msk};
  end

  // one answer per request, one cycle after it is seen
  always_ff @(posedge clk_sys_in or negedge rst_n)
    if (!rst_n)
    begin
      wb_ack_out <= 1'b0;
      wb_rty_out <= 1'b0;
      wb_dat_out <= 32'h0000_0000;
    end
    else if (ce_in)
    begin
      wb_ack_out <= req && !retry;
      wb_rty_out <= req && retry; // RULE3 RULE12
      if (req && !retry && !wb_we_in)
        wb_dat_out <= rdata;
    end
endmodule // eal_autoload_top
`default_nettype wire

// File: core/eal_pkg.sv
// Purpose: shared constants and types of the configuration autoloader
// Assumes: 50 MHz system clock, 16-bit wide serial configuration memory
// Notes:   byte offsets on a 32-bit classic Wishbone bus
package eal_pkg;
  localparam int CLK_MHZ        = 50;
  localparam int SK_HALF_NS     = 1000;
  localparam int SK_HALF_CYC    = (SK_HALF_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] DIV_LAST = 8'(SK_HALF_CYC - 1);
  localparam int START_DLY_CYC  = 8;
  localparam logic [3:0] DLY_LAST = 4'(START_DLY_CYC - 1);
  localparam int WORDS          = 18;
  localparam logic [4:0] WORD_LAST = 5'(WORDS - 1);
  localparam logic [7:0] SUM_OK = 8'hFF;
  // serial read frame: start bit, opcode 10, 6 address bits, 16 data bits
  localparam logic [2:0] RD_OPC = 3'h6;
  localparam int BITS_OUT       = 9;
  localparam int BITS_TOT       = 25;
  localparam logic [4:0] BIT_FIRST_IN = 5'(BITS_OUT);
  localparam logic [4:0] BIT_LAST = 5'(BITS_TOT - 1);
  // word slots of the memory image
  localparam int W_SHADOW_N     = 8;
  localparam int W_UNA          = 8;
  localparam int W_UNB          = 9;
  localparam int W_BURST        = 10;
  localparam int W_MISC         = 11;
  // register byte offsets
  localparam logic [7:0] A_SHADOW0 = 8'h00;
  localparam logic [7:0] A_SHADOW3 = 8'h0C;
  localparam logic [7:0] A_MISC    = 8'h10;
  localparam logic [7:0] A_UNA     = 8'h14;
  localparam logic [7:0] A_UNB     = 8'h18;
  localparam logic [7:0] A_BURST   = 8'h1C;
  localparam logic [7:0] A_EECTL   = 8'h20;
  localparam logic [7:0] A_IRQST   = 8'h40;
  localparam logic [7:0] A_IRQMSK  = 8'h44;
  localparam logic [7:0] IO_LIMIT  = 8'h40;
  // field positions
  localparam int B_ADDR_WE = 8;
  localparam int B_RELOAD_REQUEST_BIT   = 15;
  localparam int B_CONTENTS_VALID_BIT  = 13;
  localparam int B_EEN     = 4;
  localparam int B_ECS     = 3;
  localparam int B_ESK     = 2;
  localparam int B_EDI     = 1;
  localparam int B_EDO     = 0;
  localparam int I_DONE    = 0;
  localparam int I_CSUM    = 1;
  localparam int I_ABSENT  = 2;
  // values after reset
  localparam logic [15:0] MISC_RST  = 16'h0000;
  localparam logic [15:0] UNA_RST   = 16'h0000;
  localparam logic [15:0] UNB_RST   = 16'h0000;
  localparam logic [15:0] BURST_RST = 16'h0000;
  typedef enum logic [1:0] {R_IDLE = 2'h0, R_SHIFT = 2'h1, R_GAP = 2'h3} eal_rstate_t;
  typedef enum logic [2:0] {
    L_IDLE  = 3'h0,
    L_DELAY = 3'h1,
    L_START = 3'h3,
    L_WAIT  = 3'h2,
    L_APPLY = 3'h6,
    L_END   = 3'h7
  } eal_lstate_t;
endpackage

// File: core/eal_word_reader.sv
// Purpose: reads one 16-bit word from the serial memory
// Assumes: do_in already synchronised, start_in only while idle
// Notes:   data bit sampled just before each rising serial clock
`timescale 1ns/1ps
`default_nettype none
module eal_word_reader (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        ce_in,
  input  wire logic        start_in,
  input  wire logic [5:0]  addr_in,
  input  wire logic        do_in,
  output logic             busy_out,
  output logic             done_out,
  output logic [15:0]      word_out,
  output logic             sk_out,
  output logic             cs_out,
  output logic             di_out
);
  eal_pkg::eal_rstate_t state;
  logic [7:0] div;
  logic [4:0] bitn;
  logic [8:0] sh;
  logic       tick;

  assign tick     = (div == eal_pkg::DIV_LAST);
  assign busy_out = (state != eal_pkg::R_IDLE);

  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      div <= 8'h00;
    else if (ce_in)
      div <= (!busy_out || tick) ? 8'h00 : div + 8'h01;

  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
    begin
      state    <= eal_pkg::R_IDLE;
      done_out <= 1'b0;
      sk_out   <= 1'b0;
      cs_out   <= 1'b0;
      di_out   <= 1'b0;
      bitn     <= 5'h00;
      sh       <= 9'h000;
    end
    else if (ce_in)
    begin
      done_out <= 1'b0;
      case (state)
        eal_pkg::R_IDLE:
          if (start_in)
          begin
            state  <= eal_pkg::R_SHIFT; // RULE17
            cs_out <= 1'b1;
            sk_out <= 1'b0;
            bitn   <= 5'h00;
            sh     <= {eal_pkg::RD_OPC, addr_in};
            di_out <= eal_pkg::RD_OPC[2];
          end
        eal_pkg::R_SHIFT:
          if (tick && !sk_out)
            sk_out <= 1'b1;
          else if (tick)
          begin
            sk_out <= 1'b0;
            if (bitn == eal_pkg::BIT_LAST)
            begin
              state  <= eal_pkg::R_GAP;
              cs_out <= 1'b0;
              di_out <= 1'b0;
            end
            else
            begin
              bitn   <= bitn + 5'h01;
              sh     <= {sh[7:0], 1'b0};
              di_out <= sh[7];
            end
          end
        eal_pkg::R_GAP:
          if (tick)
          begin
            state    <= eal_pkg::R_IDLE;
            done_out <= 1'b1;
          end
        default:
          state <= eal_pkg::R_IDLE;
      endcase
    end

  // 16 data bits shift in msb first
  always_ff @(posedge clk_in or negedge rst_n_in)
    if (!rst_n_in)
      word_out <= 16'h0000;
    else if (ce_in && state == eal_pkg::R_SHIFT && tick && !sk_out
             && bitn >= eal_pkg::BIT_FIRST_IN)
      word_out <= {word_out[14:0], do_in}; // RULE2 RULE17
endmodule // eal_word_reader
`default_nettype wire

// File: verif/eal_autoload_assertions.sv
// Purpose: port-level checks of the configuration autoloader
// Assumes: ce_in held high, classic Wishbone master
// Notes:   software pin control must not toggle sk faster than a load would
`timescale 1ns/1ps
`default_nettype none
module eal_autoload_assertions (
  input wire logic        clk_sys_in,
  input wire logic        rst_n_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [7:0]  wb_adr_in,
  input wire logic [3:0]  wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic        wb_ack_out,
  input wire logic        wb_rty_out,
  input wire logic        sclk_led_pin_out,
  input wire logic        sclk_led_pin_oe_out,
  input wire logic        ee_cs_out,
  input wire logic        ee_di_out,
  input wire logic        irq_out
);
  logic [4:0] since;
  logic       req;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  assign req = wb_cyc_in && wb_stb_in && !wb_ack_out && !wb_rty_out;
  // load lasts at least sync plus start delay, so early io must retry
  always_ff @(posedge clk_sys_in or negedge rst_n_in)
    if (!rst_n_in) since <= 5'h00;
    else if (since != 5'h1F) since <= since + 5'h01;
  a_ack_rty_excl: assert property (!(wb_ack_out && wb_rty_out))
    else $error("ack and retry at once");
  a_answer_next: assert property ($rose(wb_cyc_in && wb_stb_in) |=> wb_ack_out ^ wb_rty_out)
    else $error("request not answered next cycle");
  a_io_early_retry: assert property (req && wb_adr_in < 8'h40 && since < 5'h09 |=> wb_rty_out)
    else $error("io access during load not retried");
  a_cfg_accepted: assert property (req && wb_adr_in >= 8'h40 |=> wb_ack_out)
    else $error("configuration access refused");
  a_rty_only_io: assert property (wb_rty_out |-> wb_adr_in < 8'h40)
    else $error("retry outside io window");
  a_pins_quiet_start: assert property ($rose(rst_n_in) |-> (!ee_cs_out && !sclk_led_pin_oe_out)[*8])
    else $error("serial pins active right after reset");
  a_cs_with_sk: assert property ($rose(sclk_led_pin_out) && sclk_led_pin_oe_out |-> ee_cs_out)
    else $error("serial clock rose without select");
  a_di_hold_sk: assert property (ee_cs_out && sclk_led_pin_out && $past(sclk_led_pin_out) |-> $stable(ee_di_out))
    else $error("data changed while serial clock high");
  a_mask_clears_irq: assert property (wb_ack_out && wb_we_in && wb_adr_in == 8'h44 && wb_sel_in[0] && wb_dat_in[2:0] == 3'h0 |-> ##[1:2] !irq_out)
    else $error("irq stays up with mask cleared");
endmodule // eal_autoload_assertions
bind eal_autoload_top eal_autoload_assertions chk_u (.clk_sys_in, .rst_n_in, .wb_cyc_in, .wb_stb_in,
  .wb_we_in, .wb_adr_in, .wb_sel_in, .wb_dat_in, .wb_ack_out, .wb_rty_out, .sclk_led_pin_out,
  .sclk_led_pin_oe_out, .ee_cs_out, .ee_di_out, .irq_out);
`default_nettype wire

// File: verif/eal_mem_model.sv
// Purpose: behavioural three-wire serial configuration memory
// Assumes: di changes while sk low, do sampled before each sk rise
// Notes:   released data line flips so no stale bit can pass for data
`timescale 1ns/1ps
`default_nettype none
module eal_mem_model (
  input  wire logic sk_in,
  input  wire logic cs_in,
  input  wire logic di_in,
  output var logic  do_out,
  output var int    frames_out,
  output var logic  bad_out
);
  logic [15:0] mem [0:63];
  logic [8:0]  hdr;
  logic [15:0] sh;
  int          n = 0;
  initial do_out = 1'b0;
  initial frames_out = 0;
  initial bad_out = 1'b0;
  always @(negedge cs_in)
  begin
    if (n >= 25) frames_out = frames_out + 1;
    n = 0;
    do_out = ~do_out;
  end
  always @(posedge sk_in)
    if (cs_in === 1'b1)
    begin
      if (n < 9) hdr = {hdr[7:0], di_in};
      n = n + 1;
      if (n == 9)
      begin
        if (hdr[8:6] !== 3'h6 || hdr[5:0] !== 6'(frames_out % 18)) bad_out = 1'b1;
        sh = mem[hdr[5:0]];
      end
      if (n >= 9 && n < 25)
      begin
        do_out = sh[15];
        sh = sh << 1;
      end
    end
endmodule // eal_mem_model
`default_nettype wire

// File: verif/testbench.sv
// Purpose: self-checking bench for the configuration autoloader
// Assumes: ack or retry one cycle after a taken request
// Notes:   one memory load costs about 46k cycles; two full loads run, near the budget
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct {logic r; logic rd; logic [31:0] e; logic [31:0] m;} eal_note_t;
  logic        clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, strap = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, r;
  logic [15:0] img [0:17];
  logic [7:0]  s;
  wire logic [31:0] rdat;
  wire logic   ack, rty, pout, poe, cs, di, dout, irq, bad, pin;
  int          frames, mismatches = 0, checks = 0, seed = 67322, ncyc = 0;
  eal_note_t   q[$];
  assign pin = poe ? pout : strap; // released pin sits at its strap level
  eal_autoload_top dut_u (.clk_sys_in(clk), .rst_n_in(rst_n), .ce_in(1'b1), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat),
    .wb_dat_out(rdat), .wb_ack_out(ack), .wb_rty_out(rty), .sclk_led_pin_in(pin),
    .sclk_led_pin_out(pout), .sclk_led_pin_oe_out(poe), .ee_cs_out(cs), .ee_di_out(di),
    .ee_do_in(dout), .irq_out(irq));
  eal_mem_model mem_u (.sk_in(pin), .cs_in(cs), .di_in(di), .do_out(dout), .frames_out(frames),
    .bad_out(bad));
  initial forever #10 clk = ~clk;
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task acc(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] sl,
           input logic rt, input logic [31:0] e, input logic [31:0] m);
    eal_note_t n;
    n = '{rt, !w, e, m};
    q.push_back(n);
    @(posedge clk);
    {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, d, sl};
    do @(posedge clk); while (ack !== 1'b1 && rty !== 1'b1);
    {cyc, stb} <= 2'h0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, 4'hF, 1'b0, e, 32'hFFFF_FFFF);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, 4'hF, 1'b0, 32'h0, 32'h0);
  endtask
  task wirq(input int lim);
    for (int t = 0; t < lim && irq !== 1'b1; t++) @(posedge clk);
    cmp("irq", 32'h1, {31'h0, irq});
  endtask
  task pins(input logic [31:0] d, input logic [3:0] e);
    wr(8'h20, d);
    repeat (3) @(posedge clk);
    cmp("pins", {28'h0, e}, {28'h0, poe, pout, cs, di});
  endtask
  always @(posedge clk)
  begin
    ncyc <= ncyc + 1;
    if (ncyc == 99000)
    begin
      mismatches++;
      print_verdict;
    end
  end
  always @(posedge clk)
    if (ack === 1'b1 || rty === 1'b1)
    begin : mon
      eal_note_t n;
      n = q.pop_front();
      cmp("retry", {31'h0, n.r}, {31'h0, rty});
      if (n.rd && ack === 1'b1) cmp("read data", n.e & n.m, rdat & n.m);
    end
  initial
  begin
    s = 8'h00;
    for (int i = 0; i < 18; i++)
    begin
      img[i] = 16'($random(seed));
      if (i == 17) img[i][15:8] = 8'hFF - s - img[i][7:0];
      s = s + img[i][7:0] + img[i][15:8];
      mem_u.mem[i] = img[i];
    end
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    acc(1'b0, 8'h10, 32'h0, 4'hF, 1'b1, 32'h0, 32'h0);
    acc(1'b1, 8'h20, 32'h1E, 4'hF, 1'b1, 32'h0, 32'h0);
    wr(8'h44, 32'h7);
    rd(8'h40, 32'h0);
    wirq(50000);
    rd(8'h40, 32'h1);
    acc(1'b0, 8'h20, 32'h0, 4'hF, 1'b0, 32'h2000, 32'hFFFF_FFFE);
    rd(8'h10, {16'h0, img[11]});
    rd(8'h14, {16'h0, img[8]});
    rd(8'h18, {16'h0, img[9]});
    rd(8'h1C, {16'h0, img[10]});
    for (int k = 0; k < 4; k++) rd(8'(4 * k), {img[2 * k + 1], img[2 * k]});
    cmp("frames", 32'd18, 32'(frames));
    cmp("frame format", 32'h0, {31'h0, bad});
    wr(8'h44, 32'h0);
    repeat (3) @(posedge clk);
    cmp("irq masked", 32'h0, {31'h0, irq});
    wr(8'h44, 32'h1);
    wirq(4);
    wr(8'h40, 32'h1);
    repeat (3) @(posedge clk);
    cmp("irq cleared", 32'h0, {31'h0, irq});
    r = $random(seed);
    wr(8'h10, 32'h0);
    wr(8'h00, ~r);
    rd(8'h00, {img[1], img[0]});
    wr(8'h10, {16'h0, r[15:9], 1'b1, r[7:0]});
    rd(8'h10, {16'h0, r[15:9], 1'b1, r[7:0]});
    wr(8'h00, r);
    rd(8'h00, r);
    pins(32'h1E, 4'hF);
    pins(32'h10, 4'h8);
    pins(32'h00, 4'h0);
    mem_u.mem[0] = img[0] ^ 16'h0001;
    acc(1'b1, 8'h20, 32'h8000, 4'h2, 1'b0, 32'h0, 32'h0);
    wirq(50000);
    rd(8'h40, 32'h3);
    acc(1'b0, 8'h20, 32'h0, 4'hF, 1'b0, 32'h0, 32'hFFFF_FFFE);
    rd(8'h10, 32'h0);
    rd(8'h14, 32'h0);
    rd(8'h00, {img[1], img[0] ^ 16'h0001});
    cmp("frame format", 32'h0, {31'h0, bad});
    strap <= 1'b0;
    rst_n <= 1'b0;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    wr(8'h44, 32'h4);
    wirq(100);
    rd(8'h40, 32'h4);
    acc(1'b0, 8'h20, 32'h0, 4'hF, 1'b0, 32'h0, 32'hFFFF_FFFE);
    rd(8'h10, 32'h0);
    cmp("frames", 32'd36, 32'(frames));
    wr(8'h40, 32'h4);
    acc(1'b1, 8'h20, 32'h8000, 4'h2, 1'b0, 32'h0, 32'h0);
    acc(1'b0, 8'h10, 32'h0, 4'hF, 1'b1, 32'h0, 32'h0);
    wirq(100);
    rd(8'h40, 32'h4);
    print_verdict;
  end
endmodule // testbench
`default_nettype wire
